// ---- byte_block_link_pkg.sv ----
// constants and types shared by the byte block link design
// assumes one 10 MHz system clock; link pins arrive unsynchronised
package byte_block_link_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int HALF_W = 4;
  // least time, so rounded up to whole cycles
  localparam int LINK_HALF_CYCLES_I = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [HALF_W-1:0] LINK_HALF_CYCLES = HALF_W'(LINK_HALF_CYCLES_I);
  localparam int RDY_DROP_NS = 80;
  // longest time, rounded down but never below one cycle
  localparam int RDY_DROP_CYCLES = (RDY_DROP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   RDY_DROP_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;
  localparam int LEN_W = 16;
  localparam int FIFO_DEPTH = 8192;
  localparam int CNT_W = 14;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SYNC_BITS = 11;
  localparam int SYN_TCLK = 10;
  localparam int SYN_RDY = 9;
  localparam int SYN_SYNC = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [LEN_W-1:0] BLOCK_LEN_RESET = 16'h0800;
  localparam logic OE_N_RESET = 1'b1;
  localparam logic TERM_RESET = 1'b0;

  typedef enum logic [1:0] {MST_IDLE, MST_HIGH, MST_LOW} mst_state_t;

endpackage

// ---- byte_block_link.sv ----
// byte block link: one clock-sourcing receive port and one ready-driven send port
// assumes host-side and control inputs are on I_CLK; link pins are asynchronous

// ------------------------------------------------------------------
// word fifo
// ------------------------------------------------------------------
// depth must be a power of two; read data is show-ahead and registered
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8192
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic wr_fire;
  logic rd_fire;

  assign wr_fire = i_wr_valid & o_wr_ready;
  assign rd_fire = i_rd_ready & o_rd_valid;

  always_comb begin
    next_rd_ptr = rd_fire ? rd_ptr + 1'b1 : rd_ptr;
    next_count = o_count + {{AW{1'b0}}, wr_fire} - {{AW{1'b0}}, rd_fire};
  end

  always_ff @(posedge i_clk) begin
    if (wr_fire) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
      o_rd_valid <= 1'b0;
      o_wr_ready <= 1'b1;
    end else begin
      if (wr_fire) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      o_count <= next_count;
      o_rd_valid <= next_count != '0;
      o_wr_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

  // bypass covers a write into the slot about to be shown
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else if (wr_fire && wr_ptr == next_rd_ptr) begin
      o_rd_data <= i_wr_data;
    end else begin
      o_rd_data <= mem[next_rd_ptr];
    end
  end
endmodule

// Operation
// - the sender raises ready to ask for a transfer and the receiver starts clocking on it.
// - only the receiving port drives the link clock, and only while enabled and ready is seen.
// - the sender changes data and sync on a rising link edge, the receiver samples on a falling one.
// - every link clock carries one byte on eight parallel data lines.
// - sync goes out with the first byte and with the first byte of every later block.
// - the block length is a whole number of 32-bit words, usually 2048 bytes.
// - each port has its own programmable block length, for sending and for checking.
// - a misplaced sync sets the sticky error flag while reception carries on.
// - ready stays low until the send fifo holds a whole block.
// - the receiver may stop the clock at any time and the sender moves only on real edges.
// - each port has its own 8K by 32 fifo loaded or drained one host word at a time.
// - after reset every line is receiving; enabling either port opens both its drivers and its terminations.
// - host-side data is handled as whole 32-bit words.
// - the first link byte is bits 7 to 0 of the word unless swap takes it from bits 31 to 24.
// - ready drops together with the last byte of a block so the receiver can stop between blocks.
module byte_block_link (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_TGT_ENABLE,
  input wire logic [15:0] I_TGT_BLOCK_LEN,
  input wire logic I_TGT_SWAP,
  input wire logic I_TGT_WR_VALID,
  input wire logic [31:0] I_TGT_WR_DATA,
  output logic O_TGT_WR_READY,
  input wire logic I_TGT_LINK_CLK,
  output logic O_TGT_READY,
  output logic O_TGT_SYNC,
  output logic [7:0] O_TGT_DATA,
  output logic O_TGT_OE_N,
  output logic O_TGT_TERM_EN,
  input wire logic I_MST_ENABLE,
  input wire logic [15:0] I_MST_BLOCK_LEN,
  input wire logic I_MST_SWAP,
  input wire logic I_MST_ERR_CLEAR,
  output logic O_MST_SYNC_ERR,
  output logic O_MST_RD_VALID,
  output logic [31:0] O_MST_RD_DATA,
  input wire logic I_MST_RD_READY,
  output logic O_MST_LINK_CLK,
  output logic O_MST_OE_N,
  output logic O_MST_TERM_EN,
  input wire logic I_MST_READY,
  input wire logic I_MST_SYNC,
  input wire logic [7:0] I_MST_DATA
);
  localparam int BW = byte_block_link_pkg::BYTE_W;
  localparam int WW = byte_block_link_pkg::WORD_W;
  localparam int LW = byte_block_link_pkg::LEN_W;
  localparam int CW = byte_block_link_pkg::CNT_W;
  localparam int HW = byte_block_link_pkg::HALF_W;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [byte_block_link_pkg::SYNC_BITS-1:0] pin_raw;
  logic [byte_block_link_pkg::SYNC_BITS-1:0] pin_f;

  assign pin_raw = {I_TGT_LINK_CLK, I_MST_READY, I_MST_SYNC, I_MST_DATA};

  // a change counts only once stages two and three agree
  for (genvar b = 0; b < byte_block_link_pkg::SYNC_BITS; b++) begin : g_pin
    logic r1;
    logic r2;
    logic r3;
    logic f;
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
        r1 <= 1'b0;
        r2 <= 1'b0;
        r3 <= 1'b0;
        f <= 1'b0;
      end else begin
        r1 <= pin_raw[b];
        r2 <= r1;
        r3 <= r2;
        if (r2 == r3) begin
          f <= r3;
        end
      end
    end
    assign pin_f[b] = f;
  end

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k,
                                         input logic swap);
    logic [1:0] j;
    j = swap ? ~k : k;
    return w[j*BW +: BW];
  endfunction

  // ----------------------------------------------------------------
  // line direction and termination
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TGT_OE_N <= byte_block_link_pkg::OE_N_RESET;
      O_TGT_TERM_EN <= byte_block_link_pkg::TERM_RESET;
      O_MST_OE_N <= byte_block_link_pkg::OE_N_RESET;
      O_MST_TERM_EN <= byte_block_link_pkg::TERM_RESET;
    end else begin
      O_TGT_OE_N <= ~I_TGT_ENABLE;
      O_TGT_TERM_EN <= I_TGT_ENABLE;
      O_MST_OE_N <= ~I_MST_ENABLE;
      O_MST_TERM_EN <= I_MST_ENABLE;
    end
  end

  // ----------------------------------------------------------------
  // send port fifo
  // ----------------------------------------------------------------
  logic tf_rd_valid;
  logic [WW-1:0] tf_rd_data;
  logic tf_rd_ready;
  logic [CW-1:0] tf_count;

  word_fifo #(
    .WIDTH(WW),
    .DEPTH(byte_block_link_pkg::FIFO_DEPTH)
  ) u_tgt_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_wr_valid(I_TGT_WR_VALID),
    .i_wr_data(I_TGT_WR_DATA),
    .o_wr_ready(O_TGT_WR_READY),
    .o_rd_valid(tf_rd_valid),
    .o_rd_data(tf_rd_data),
    .i_rd_ready(tf_rd_ready),
    .o_count(tf_count)
  );

  // ----------------------------------------------------------------
  // send port
  // ----------------------------------------------------------------
  logic tclk_prev;
  logic tclk_rise;
  logic long_word_multiple;
  logic enough;
  logic tx_gap;
  logic [LW-1:0] tx_cnt;
  logic [LW-1:0] blk_len;
  logic [WW-1:0] tx_word;
  logic tx_step;

  assign tclk_rise = pin_f[byte_block_link_pkg::SYN_TCLK] & ~tclk_prev;
  assign long_word_multiple = I_TGT_BLOCK_LEN != '0 && I_TGT_BLOCK_LEN[1:0] == 2'h0;
  assign enough = tf_count >= I_TGT_BLOCK_LEN[LW-1:2];
  assign tx_step = O_TGT_READY & tclk_rise & I_TGT_ENABLE;
  assign tf_rd_ready = tx_step & (tx_cnt[1:0] == 2'h0);

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tclk_prev <= 1'b0;
    end else begin
      tclk_prev <= pin_f[byte_block_link_pkg::SYN_TCLK];
    end
  end

  // ready is held low until the clock is seen low, so a one-cycle dip is never missed
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TGT_READY <= 1'b0;
      tx_cnt <= '0;
      tx_gap <= 1'b0;
      blk_len <= byte_block_link_pkg::BLOCK_LEN_RESET;
    end else if (!I_TGT_ENABLE) begin
      O_TGT_READY <= 1'b0;
      tx_cnt <= '0;
      tx_gap <= 1'b0;
    end else if (!O_TGT_READY) begin
      if (tx_gap) begin
        tx_gap <= pin_f[byte_block_link_pkg::SYN_TCLK];
      end else if (long_word_multiple && enough) begin
        O_TGT_READY <= 1'b1;
        tx_cnt <= '0;
        blk_len <= I_TGT_BLOCK_LEN;
      end
    end else if (tx_step) begin
      if (tx_cnt == blk_len - 16'h0001) begin
        O_TGT_READY <= 1'b0;
        tx_cnt <= '0;
        tx_gap <= 1'b1;
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TGT_SYNC <= 1'b0;
      O_TGT_DATA <= '0;
      tx_word <= '0;
    end else if (tx_step) begin
      O_TGT_SYNC <= tx_cnt == '0;
      if (tx_cnt[1:0] == 2'h0) begin
        O_TGT_DATA <= byte_of(tf_rd_data, 2'h0, I_TGT_SWAP);
        tx_word <= tf_rd_data;
      end else begin
        O_TGT_DATA <= byte_of(tx_word, tx_cnt[1:0], I_TGT_SWAP);
      end
    end
  end

  // ----------------------------------------------------------------
  // receive port clock
  // ----------------------------------------------------------------
  byte_block_link_pkg::mst_state_t state;
  logic [HW-1:0] phase;
  logic go;
  logic cap;
  logic cap_sync;
  logic [BW-1:0] cap_byte;
  logic mf_wr_ready;

  // a full fifo stops the clock rather than losing bytes
  assign go = I_MST_ENABLE & pin_f[byte_block_link_pkg::SYN_RDY] & mf_wr_ready;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state <= byte_block_link_pkg::MST_IDLE;
      phase <= '0;
      O_MST_LINK_CLK <= 1'b0;
      cap <= 1'b0;
      cap_sync <= 1'b0;
      cap_byte <= '0;
    end else begin
      cap <= 1'b0;
      case (state)
        byte_block_link_pkg::MST_IDLE: begin
          if (go) begin
            O_MST_LINK_CLK <= 1'b1;
            phase <= '0;
            state <= byte_block_link_pkg::MST_HIGH;
          end
        end
        byte_block_link_pkg::MST_HIGH: begin
          if (phase == byte_block_link_pkg::LINK_HALF_CYCLES - 4'h1) begin
            O_MST_LINK_CLK <= 1'b0;
            phase <= '0;
            state <= byte_block_link_pkg::MST_LOW;
          end else begin
            phase <= phase + 4'h1;
          end
        end
        byte_block_link_pkg::MST_LOW: begin
          if (phase == byte_block_link_pkg::LINK_HALF_CYCLES - 4'h1) begin
            // synced pins lag four cycles: they now show the line at the falling edge
            cap <= 1'b1;
            cap_byte <= pin_f[BW-1:0];
            cap_sync <= pin_f[byte_block_link_pkg::SYN_SYNC];
            phase <= '0;
            if (go) begin
              O_MST_LINK_CLK <= 1'b1;
              state <= byte_block_link_pkg::MST_HIGH;
            end else begin
              state <= byte_block_link_pkg::MST_IDLE;
            end
          end else begin
            phase <= phase + 4'h1;
          end
        end
        default: begin
          state <= byte_block_link_pkg::MST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive port packing
  // ----------------------------------------------------------------
  logic [WW-1:0] rx_word;
  logic [WW-1:0] next_word;
  logic [1:0] rx_idx;
  logic push;
  logic [WW-1:0] push_data;

  always_comb begin
    next_word = I_MST_SWAP ? {rx_word[23:0], cap_byte} : {cap_byte, rx_word[31:8]};
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_word <= '0;
      rx_idx <= '0;
      push <= 1'b0;
      push_data <= '0;
    end else begin
      push <= 1'b0;
      if (cap) begin
        rx_word <= next_word;
        rx_idx <= rx_idx + 2'h1;
        if (rx_idx == 2'h3) begin
          push <= 1'b1;
          push_data <= next_word;
        end
      end
    end
  end

  word_fifo #(
    .WIDTH(WW),
    .DEPTH(byte_block_link_pkg::FIFO_DEPTH)
  ) u_mst_fifo (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_wr_valid(push),
    .i_wr_data(push_data),
    .o_wr_ready(mf_wr_ready),
    .o_rd_valid(O_MST_RD_VALID),
    .o_rd_data(O_MST_RD_DATA),
    .i_rd_ready(I_MST_RD_READY),
    .o_count()
  );

  // ----------------------------------------------------------------
  // receive port sync check
  // ----------------------------------------------------------------
  logic [LW-1:0] rx_cnt;
  logic seen_sync;
  logic sync_bad;

  assign sync_bad = cap & seen_sync &
                    (cap_sync ? rx_cnt != I_MST_BLOCK_LEN : rx_cnt == I_MST_BLOCK_LEN);

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rx_cnt <= '0;
      seen_sync <= 1'b0;
    end else if (cap) begin
      if (cap_sync || (seen_sync && rx_cnt == I_MST_BLOCK_LEN)) begin
        rx_cnt <= 16'h0001;
        seen_sync <= 1'b1;
      end else if (seen_sync) begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
    end
  end

  // set beats clear; reception is never stopped by an error
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_MST_SYNC_ERR <= 1'b0;
    end else begin
      O_MST_SYNC_ERR <= (O_MST_SYNC_ERR & ~I_MST_ERR_CLEAR) | sync_bad;
    end
  end
endmodule

// ---- byte_block_link_properties.sv ----
// port-level checker for the byte block link, bound to the top module
// assumes one I_CLK domain and the asynchronous active-high I_SYS_RST
// ------------------------------------------------------------------
// checker
// ------------------------------------------------------------------
module byte_block_link_checker (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_TGT_ENABLE,
  input wire logic I_TGT_LINK_CLK,
  input wire logic O_TGT_READY,
  input wire logic O_TGT_SYNC,
  input wire logic [7:0] O_TGT_DATA,
  input wire logic O_TGT_OE_N,
  input wire logic O_TGT_TERM_EN,
  input wire logic I_MST_ENABLE,
  input wire logic I_MST_ERR_CLEAR,
  input wire logic O_MST_SYNC_ERR,
  input wire logic O_MST_RD_VALID,
  input wire logic [31:0] O_MST_RD_DATA,
  input wire logic I_MST_RD_READY,
  input wire logic O_MST_LINK_CLK,
  input wire logic O_MST_OE_N,
  input wire logic O_MST_TERM_EN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  AST_RESET_IDLE:
    assert property ($fell(I_SYS_RST) |-> O_TGT_OE_N && O_MST_OE_N && !O_TGT_READY
      && !O_MST_LINK_CLK && !O_MST_SYNC_ERR) else $error("outputs not idle after reset");
  AST_TGT_OFF:
    assert property (!I_TGT_ENABLE |=> O_TGT_OE_N && !O_TGT_TERM_EN)
      else $error("send drivers on while disabled");
  AST_MST_ON:
    assert property (I_MST_ENABLE |=> !O_MST_OE_N && O_MST_TERM_EN)
      else $error("receive port pins not set up");
  AST_NO_CLK_OFF:
    assert property (!I_MST_ENABLE ##1 !I_MST_ENABLE |=> !$rose(O_MST_LINK_CLK))
      else $error("link clock started while disabled");
  AST_CLK_SHAPE:
    assert property ($rose(O_MST_LINK_CLK) |-> O_MST_LINK_CLK[*4] ##1 !O_MST_LINK_CLK[*4])
      else $error("link clock phases wrong");
  AST_RDY_ENABLED:
    assert property ($rose(O_TGT_READY) |-> $past(I_TGT_ENABLE) && !O_TGT_OE_N)
      else $error("ready raised while disabled");
  AST_SYNC_IN_BLOCK:
    assert property ($rose(O_TGT_SYNC) |-> O_TGT_READY)
      else $error("sync outside a block");
  AST_DATA_HELD:
    assert property (!I_TGT_LINK_CLK[*6] |=> $stable(O_TGT_DATA) && $stable(O_TGT_SYNC))
      else $error("send data moved without a link clock");
  AST_ERR_STICKY:
    assert property (O_MST_SYNC_ERR && !I_MST_ERR_CLEAR |=> O_MST_SYNC_ERR)
      else $error("sync error lost without clear");
  AST_RD_HELD:
    assert property (O_MST_RD_VALID && !I_MST_RD_READY |=> O_MST_RD_VALID
      && $stable(O_MST_RD_DATA)) else $error("receive word changed before pop");

  COV_READY: cover property ($rose(O_TGT_READY));
  COV_LINK_CLK: cover property ($rose(O_MST_LINK_CLK));
  COV_SYNC_ERR: cover property ($rose(O_MST_SYNC_ERR));
endmodule

bind byte_block_link byte_block_link_checker chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_TGT_ENABLE(I_TGT_ENABLE), .I_TGT_LINK_CLK(I_TGT_LINK_CLK), .O_TGT_READY(O_TGT_READY),
  .O_TGT_SYNC(O_TGT_SYNC), .O_TGT_DATA(O_TGT_DATA), .O_TGT_OE_N(O_TGT_OE_N),
  .O_TGT_TERM_EN(O_TGT_TERM_EN), .I_MST_ENABLE(I_MST_ENABLE),
  .I_MST_ERR_CLEAR(I_MST_ERR_CLEAR), .O_MST_SYNC_ERR(O_MST_SYNC_ERR),
  .O_MST_RD_VALID(O_MST_RD_VALID), .O_MST_RD_DATA(O_MST_RD_DATA),
  .I_MST_RD_READY(I_MST_RD_READY), .O_MST_LINK_CLK(O_MST_LINK_CLK),
  .O_MST_OE_N(O_MST_OE_N), .O_MST_TERM_EN(O_MST_TERM_EN));

// ---- far_link_model.sv ----
// far side of both links: clock source for the send port, byte source for the receive port
// assumes the bench fills tx_q, calls start and reads rx_q by hierarchical name
// ------------------------------------------------------------------
// far link model
// ------------------------------------------------------------------
module far_link_model (
  input wire logic i_tgt_ready,
  input wire logic i_tgt_sync,
  input wire logic [7:0] i_tgt_data,
  output logic o_tgt_link_clk,
  input wire logic i_mst_link_clk,
  output logic o_mst_ready,
  output logic o_mst_sync,
  output logic [7:0] o_mst_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] rx_q[$];
  logic [8:0] tx_q[$];

  // clock only while ready is seen, stands low between blocks
  initial begin
    o_tgt_link_clk = 1'b0;
    forever begin
      wait (i_tgt_ready === 1'b1);
      #50 o_tgt_link_clk = 1'b1;
      #400 o_tgt_link_clk = 1'b0;
      // late in the low phase: the send port answers a rise about 450 ns on
      #300 rx_q.push_back({i_tgt_sync, i_tgt_data});
      #50;
    end
  end

  task automatic start();
    o_mst_ready = 1'b1;
  endtask

  initial begin
    o_mst_ready = 1'b0;
    o_mst_sync = 1'b0;
    o_mst_data = 8'h00;
  end

  always @(posedge i_mst_link_clk) begin
    #20;
    if (tx_q.size() > 0) {o_mst_sync, o_mst_data} = tx_q.pop_front();
    o_mst_ready = tx_q.size() > 0;
  end

  // released lines never keep the last byte
  always @(negedge i_mst_link_clk) begin
    #20;
    if (!o_mst_ready) {o_mst_sync, o_mst_data} = ~{o_mst_sync, o_mst_data};
  end
endmodule

// ---- byte_block_link_bench.sv ----
// self-checking bench for the byte block link against the far link model
// assumes the design package, design, model and checker are compiled before it
// ------------------------------------------------------------------
// bench
// ------------------------------------------------------------------
module byte_block_link_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, tgt_en, tgt_swap, tgt_wv, mst_en, mst_swap, err_clr, rd_rdy;
  logic wr_rdy, tgt_lclk, tgt_rdy, tgt_sync, tgt_oe_n, tgt_term, mst_err, rd_valid;
  logic mst_lclk, mst_oe_n, mst_term, mst_rdy, mst_sync;
  logic [15:0] tgt_len, mst_len;
  logic [31:0] tgt_wd, rd_data;
  logic [7:0] tgt_data, mst_data;
  int error_cnt = 0;
  int check_count = 0;

  byte_block_link dut (.I_CLK(clk), .I_SYS_RST(rst), .I_TGT_ENABLE(tgt_en),
    .I_TGT_BLOCK_LEN(tgt_len), .I_TGT_SWAP(tgt_swap), .I_TGT_WR_VALID(tgt_wv),
    .I_TGT_WR_DATA(tgt_wd), .O_TGT_WR_READY(wr_rdy), .I_TGT_LINK_CLK(tgt_lclk),
    .O_TGT_READY(tgt_rdy), .O_TGT_SYNC(tgt_sync), .O_TGT_DATA(tgt_data),
    .O_TGT_OE_N(tgt_oe_n), .O_TGT_TERM_EN(tgt_term), .I_MST_ENABLE(mst_en),
    .I_MST_BLOCK_LEN(mst_len), .I_MST_SWAP(mst_swap), .I_MST_ERR_CLEAR(err_clr),
    .O_MST_SYNC_ERR(mst_err), .O_MST_RD_VALID(rd_valid), .O_MST_RD_DATA(rd_data),
    .I_MST_RD_READY(rd_rdy), .O_MST_LINK_CLK(mst_lclk), .O_MST_OE_N(mst_oe_n),
    .O_MST_TERM_EN(mst_term), .I_MST_READY(mst_rdy), .I_MST_SYNC(mst_sync),
    .I_MST_DATA(mst_data));
  far_link_model far (.i_tgt_ready(tgt_rdy), .i_tgt_sync(tgt_sync), .i_tgt_data(tgt_data),
    .o_tgt_link_clk(tgt_lclk), .i_mst_link_clk(mst_lclk), .o_mst_ready(mst_rdy),
    .o_mst_sync(mst_sync), .o_mst_data(mst_data));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic push_word(input logic [31:0] w);
    int n;
    n = 0;
    @(negedge clk);
    tgt_wd = w;
    tgt_wv = 1'b1;
    while (wr_rdy !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    @(negedge clk);
    tgt_wv = 1'b0;
  endtask

  task automatic pop_word(output logic [31:0] w);
    int n;
    n = 0;
    @(negedge clk);
    while (rd_valid !== 1'b1 && n < 400) begin
      n++;
      @(negedge clk);
    end
    w = rd_data;
    rd_rdy = 1'b1;
    @(negedge clk);
    rd_rdy = 1'b0;
  endtask

  task automatic t_reset();
    logic [8:0] v;
    v = {tgt_oe_n, mst_oe_n, tgt_term, mst_term, tgt_rdy, mst_lclk, wr_rdy, rd_valid, mst_err};
    check(32'(v), 32'h184, "idle after reset");
    @(negedge clk);
    tgt_en = 1'b1;
    mst_en = 1'b1;
    repeat (2) @(negedge clk);
    check(32'({tgt_oe_n, mst_oe_n, tgt_term, mst_term}), 32'h3, "pin setup");
    $display("reset test done");
  endtask

  task automatic t_fifo();
    int n;
    tgt_en = 1'b0;
    tgt_len = 16'h0004;
    far.rx_q.delete();
    tgt_wv = 1'b1;
    // one word more than the depth is offered while full and must be refused
    for (int i = 0; i <= byte_block_link_pkg::FIFO_DEPTH; i++) begin
      tgt_wd = 32'(i) * 32'h01010101;
      @(negedge clk);
    end
    tgt_wv = 1'b0;
    check(32'(wr_rdy), 0, "fifo full");
    tgt_en = 1'b1;
    n = 0;
    while (far.rx_q.size() < 8 && n < 200) begin
      n++;
      @(negedge clk);
    end
    tgt_en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      check(32'(far.rx_q[i]), 32'({i % 4 == 0, 8'(i / 4)}), "fifo order");
    end
    // reset in mid-run drops what is left
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(32'({wr_rdy, tgt_rdy}), 32'h2, "fifo empty after reset");
    tgt_len = 16'h0008;
    tgt_en = 1'b1;
    $display("fifo test done");
  endtask

  task automatic t_send(input logic swap);
    logic [7:0] e;
    int n;
    tgt_swap = swap;
    far.rx_q.delete();
    push_word(32'h44332211);
    repeat (20) @(negedge clk);
    check(32'(tgt_rdy), 0, "ready with half a block");
    tgt_len = 16'h0006;
    push_word(32'h88776655);
    repeat (20) @(negedge clk);
    check(32'(tgt_rdy), 0, "ready with odd length");
    tgt_len = 16'h0008;
    n = 0;
    while (far.rx_q.size() < 8 && n < 200) begin
      n++;
      @(negedge clk);
    end
    // long enough for a ninth clock if ready stayed up
    repeat (40) @(negedge clk);
    check(32'(far.rx_q.size()), 8, "bytes in block");
    check(32'(tgt_rdy), 0, "ready after block");
    for (int i = 0; i < 8; i++) begin
      e = 8'(swap ? (i / 4 * 4 + 4 - i % 4) * 17 : (i + 1) * 17);
      check(32'(far.rx_q[i]), 32'({i == 0, e}), "link byte");
    end
    $display("send test done");
  endtask

  task automatic t_recv();
    logic [31:0] w;
    for (int i = 0; i < 4; i++) far.tx_q.push_back({i == 0, 8'(8'ha0 + i)});
    far.start();
    pop_word(w);
    check(w, 32'ha3a2a1a0, "word low byte first");
    mst_swap = 1'b1;
    for (int i = 4; i < 8; i++) far.tx_q.push_back({i == 4, 8'(8'ha0 + i)});
    far.start();
    pop_word(w);
    check(w, 32'ha4a5a6a7, "word swapped");
    check(32'(mst_err), 0, "sync at block size");
    $display("receive test done");
  endtask

  task automatic t_sync_err();
    logic [31:0] w;
    for (int i = 0; i < 4; i++) far.tx_q.push_back({i == 0 || i == 2, 8'(8'hc0 + i)});
    far.start();
    pop_word(w);
    check(w, 32'hc0c1c2c3, "word after bad sync");
    check(32'(mst_err), 1, "bad sync flagged");
    @(negedge clk);
    err_clr = 1'b1;
    @(negedge clk);
    err_clr = 1'b0;
    check(32'(mst_err), 0, "error cleared");
    $display("sync error test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {tgt_en, tgt_swap, tgt_wv, mst_en, mst_swap, err_clr, rd_rdy} = '0;
    tgt_len = 16'h0008;
    mst_len = 16'h0004;
    tgt_wd = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_fifo();
    t_send(1'b0);
    t_send(1'b1);
    t_recv();
    t_sync_err();
    end_of_test();
  end

  // all tests need about 1 ms, mostly filling the send fifo
  initial begin
    #2000000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
